// >>> common/tpw_pkg.sv
// Package of constants and types for the trip-point wait unit
package tpw_pkg;
  // Time base
  localparam int CLK_PERIOD_NS = 40;
  localparam int MS_PERIOD_NS = 1000000;
  localparam int MS_CYCLES = (MS_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIME_W = 32;
  // Structural defaults
  localparam int N_AXES_DEF = 8;
  localparam int POS_W_DEF = 32;
  localparam int N_INPUTS_DEF = 80;
  // Register byte offsets
  localparam logic [7:0] ADR_STATUS = 8'h00;
  localparam logic [7:0] ADR_SETTLE = 8'h04;
  localparam logic [7:0] ADR_HALT = 8'h08;
  localparam logic [7:0] ADR_TIME = 8'h0C;
  // Field positions
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_OP_LSB = 4;
  localparam int ST_ERR_LSB = 8;
  localparam int HALT_AX_LSB = 8;
  // Reset values and the settle halt code
  localparam logic [TIME_W-1:0] SETTLE_RST = 32'h000003E8;
  localparam logic [7:0] HALT_NONE = 8'h00;
  localparam logic [7:0] HALT_SETTLE = 8'h63;
  // Sticky error flags
  localparam int ERR_W = 4;
  localparam logic [ERR_W-1:0] ERR_NONE = 4'h0;
  localparam logic [ERR_W-1:0] ERR_MULTI_M = 4'h1;
  localparam logic [ERR_W-1:0] ERR_MOVING_M = 4'h2;
  localparam logic [ERR_W-1:0] ERR_TMO_M = 4'h4;
  localparam logic [ERR_W-1:0] ERR_LINE_M = 4'h8;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_MOTION_DONE = 4'h1,
    OP_MOVE_OFFS = 4'h2,
    OP_REPEAT_OFFS = 4'h3,
    OP_FIXED_LOC = 4'h4,
    OP_FWD_CROSS = 4'h5,
    OP_REV_CROSS = 4'h6,
    OP_IN_POS = 4'h7,
    OP_IN_LEVEL = 4'h8,
    OP_CRUISE = 4'h9,
    OP_REF_TIMER = 4'hA,
    OP_PATH_LEN = 4'hB,
    OP_DELAY = 4'hC,
    OP_REL_MOVE = 4'hD
  } tpw_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01
  } tpw_state_t;
endpackage : tpw_pkg

// >>> common/tpw_tb_if.sv
// Interface carrying the millisecond time base
`timescale 1ns/100ps
interface tpw_tb_if;
  import tpw_pkg::*;
  logic ms_tick;
  logic [TIME_W-1:0] now_ms;
  modport src (output ms_tick, output now_ms);
  modport snk (input ms_tick, input now_ms);
endinterface : tpw_tb_if

// >>> src/tpw_msbase.sv
// Millisecond divider and free-running millisecond counter
`timescale 1ns/100ps
module tpw_msbase
  import tpw_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  tpw_tb_if.src tb
);
  logic [31:0] div_q;
  logic tick_q;
  logic [TIME_W-1:0] now_q;

  // Divider gives one enable pulse per millisecond
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_q <= 32'h00000000;
      tick_q <= 1'b0;
    end else if (div_q == 32'(MS_CYC - 1)) begin
      div_q <= 32'h00000000;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 32'h00000001;
      tick_q <= 1'b0;
    end
  end

  // Wraps after about 49 days; users compare differences, so wrap is harmless
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      now_q <= '0;
    end else if (tick_q) begin
      now_q <= now_q + 32'h00000001;
    end
  end

  assign tb.ms_tick = tick_q;
  assign tb.now_ms = now_q;
endmodule : tpw_msbase

// >>> src/tpw_top.sv
// Trip-point wait unit: stalls the program sequencer until a chosen condition trips
//
// Decided for this implementation: the placing of the registers and the Wishbone slave port.
`timescale 1ns/100ps
// Function
// - motion done hold waits until every listed axis or sequence stops, then advances.
// - motion done hold without axes waits for all axes and the sequence.
// - move offset hold waits for commanded travel from move start on one axis.
// - repeat offset hold measures from the previous offset trip point.
// - fixed location hold waits until one axis reaches an absolute position.
// - forward crossing hold waits for forward motion to reach the target.
// - forward crossing trips at once if already beyond the target.
// - reverse crossing likewise; both crossings may use auxiliary encoder inputs.
// - in position hold waits for profile done and encoder at or past target.
// - settle timeout releases the wait, sets halt code 99, flags an error.
// - settle timeout redirects the program to the timeout handler routine.
// - input level hold waits for a numbered input at the signed operand level.
// - cruise speed hold waits until the axis runs at slew speed.
// - negative reference timer waits then advances the reference by n ms.
// - path length hold waits until coordinated path distance reaches the value.
// - delay hold waits the given milliseconds from decode.
// - relative move is rejected with an error while its axis moves.
// - position trips are evaluated once per servo sample.
// - input level wait fully stalls the sequencer.
module tpw_top
  import tpw_pkg::*;
#(
  parameter int N_AXES = N_AXES_DEF,
  parameter int POS_W = POS_W_DEF,
  parameter int N_INPUTS = N_INPUTS_DEF,
  parameter int MS_CYC = MS_CYCLES
) (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [31:0] WB_DAT_IN,
  input wire logic [3:0] WB_SEL_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  input wire logic INSTR_VALID_IN,
  input wire logic [3:0] INSTR_OP_IN,
  input wire logic [N_AXES:0] INSTR_AXES_IN,
  input wire logic INSTR_AUX_IN,
  input wire logic [POS_W-1:0] INSTR_ARG_IN,
  output logic INSTR_READY_OUT,
  output logic HOLD_OUT,
  output logic DONE_OUT,
  output logic ERROR_OUT,
  output logic HANDLER_JUMP_OUT,
  output logic MOVE_GO_OUT,
  input wire logic SERVO_TICK_IN,
  input wire logic [N_AXES:0] MOVING_IN,
  input wire logic [N_AXES-1:0] SLEW_REACHED_IN,
  input wire logic [N_AXES*POS_W-1:0] CMD_POS_IN,
  input wire logic [N_AXES*POS_W-1:0] ENC_POS_IN,
  input wire logic [N_AXES*POS_W-1:0] AUX_POS_IN,
  input wire logic [POS_W-1:0] PATH_DIST_IN,
  input wire logic [N_INPUTS-1:0] DIG_IN
);
  localparam int AX_W = (N_AXES > 1) ? $clog2(N_AXES) : 1;
  localparam int LINE_W = (N_INPUTS > 1) ? $clog2(N_INPUTS) : 1;

  tpw_tb_if tb ();
  tpw_state_t state_q;
  tpw_op_t op_in;
  tpw_op_t op_q;
  logic signed [POS_W-1:0] cmd_pos [N_AXES];
  logic signed [POS_W-1:0] enc_pos [N_AXES];
  logic signed [POS_W-1:0] aux_pos [N_AXES];
  logic signed [POS_W-1:0] start_pos_q [N_AXES];
  logic signed [POS_W-1:0] base_q [N_AXES];
  logic [N_AXES-1:0] mov_prev_q;
  logic [AX_W-1:0] ax_d;
  logic [AX_W-1:0] ax_q;
  logic [7:0] n_sel;
  logic one_axis;
  logic single_op;
  logic accept;
  logic imm_d;
  logic dir_d;
  logic trip;
  logic trip_fire;
  logic tmo_fire;
  logic off_trip;
  logic signed [POS_W-1:0] arg_s;
  logic signed [POS_W-1:0] tgt_d;
  logic signed [POS_W-1:0] tgt_q;
  logic signed [POS_W-1:0] x_new;
  logic signed [POS_W-1:0] x_sel;
  logic [POS_W-1:0] arg_abs;
  logic [ERR_W-1:0] err_issue;
  logic [ERR_W-1:0] err_set;
  logic [ERR_W-1:0] err_clr;
  logic [ERR_W-1:0] err_q;
  logic [N_AXES:0] mask_q;
  logic aux_q;
  logic dir_q;
  logic lvl_q;
  logic [LINE_W-1:0] line_q;
  logic [TIME_W-1:0] n_q;
  logic [TIME_W-1:0] ref_q;
  logic [TIME_W-1:0] ms_cnt_q;
  logic [TIME_W-1:0] settle_q;
  logic [7:0] halt_q;
  logic [AX_W-1:0] halt_ax_q;
  logic done_q;
  logic error_q;
  logic jump_q;
  logic go_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic [31:0] rd_d;
  logic wb_hit;
  logic wb_wr;

  tpw_msbase #(.MS_CYC(MS_CYC)) u_ms (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .tb(tb.src)
  );

  assign op_in = tpw_op_t'(INSTR_OP_IN);
  assign arg_s = INSTR_ARG_IN;
  assign arg_abs = arg_s[POS_W-1] ? (~INSTR_ARG_IN + 1'b1) : INSTR_ARG_IN;
  assign accept = INSTR_VALID_IN && (state_q == ST_IDLE);

  // Per-axis slices, move-start capture and repeat base
  for (genvar a = 0; a < N_AXES; a++) begin : g_axis
    assign cmd_pos[a] = CMD_POS_IN[a*POS_W +: POS_W];
    assign enc_pos[a] = ENC_POS_IN[a*POS_W +: POS_W];
    assign aux_pos[a] = AUX_POS_IN[a*POS_W +: POS_W];
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
        mov_prev_q[a] <= 1'b0;
        start_pos_q[a] <= '0;
        base_q[a] <= '0;
      end else begin
        mov_prev_q[a] <= MOVING_IN[a];
        if (MOVING_IN[a] && !mov_prev_q[a]) begin
          start_pos_q[a] <= cmd_pos[a];
        end
        // A trip point outranks a move start landing in the same cycle
        if (off_trip && (ax_q == AX_W'(a))) begin
          base_q[a] <= tgt_q;
        end else if (MOVING_IN[a] && !mov_prev_q[a]) begin
          base_q[a] <= cmd_pos[a];
        end
      end
    end
  end

  // Lowest named axis and a count of named axes
  always_comb begin
    ax_d = '0;
    n_sel = 8'h00;
    for (int i = N_AXES - 1; i >= 0; i--) begin
      if (INSTR_AXES_IN[i]) begin
        ax_d = AX_W'(i);
        n_sel = n_sel + 8'h01;
      end
    end
  end
  assign one_axis = (n_sel == 8'h01) && !INSTR_AXES_IN[N_AXES];
  assign single_op = op_in inside {OP_MOVE_OFFS, OP_REPEAT_OFFS, OP_FIXED_LOC,
                                   OP_FWD_CROSS, OP_REV_CROSS, OP_IN_POS, OP_CRUISE};
  assign x_new = INSTR_AUX_IN ? aux_pos[ax_d] : enc_pos[ax_d];

  // Decode of a new instruction: refusal, instant trip, target and direction
  always_comb begin
    err_issue = ERR_NONE;
    case (op_in)
      OP_REL_MOVE: begin
        if ((MOVING_IN[N_AXES-1:0] & INSTR_AXES_IN[N_AXES-1:0]) != '0) begin
          err_issue = ERR_MOVING_M;
        end
      end
      OP_IN_LEVEL: begin
        if ((arg_abs == '0) || (arg_abs > POS_W'(N_INPUTS))) begin
          err_issue = ERR_LINE_M;
        end
      end
      default: begin
        if (single_op && !one_axis) begin
          err_issue = ERR_MULTI_M;
        end
      end
    endcase
  end

  always_comb begin
    imm_d = 1'b1;
    tgt_d = arg_s;
    dir_d = 1'b1;
    case (op_in)
      OP_MOTION_DONE, OP_MOVE_OFFS, OP_REPEAT_OFFS, OP_FIXED_LOC, OP_IN_POS,
      OP_IN_LEVEL, OP_CRUISE, OP_PATH_LEN: imm_d = 1'b0;
      OP_FWD_CROSS: imm_d = (x_new >= arg_s);
      OP_REV_CROSS: imm_d = (x_new <= arg_s);
      OP_REF_TIMER: imm_d = (arg_abs == '0);
      OP_DELAY: imm_d = (arg_abs == '0);
      default: imm_d = 1'b1;
    endcase
    case (op_in)
      OP_MOVE_OFFS: tgt_d = start_pos_q[ax_d] + arg_s;
      OP_REPEAT_OFFS: tgt_d = base_q[ax_d] + arg_s;
      default: tgt_d = arg_s;
    endcase
    case (op_in)
      OP_MOVE_OFFS, OP_REPEAT_OFFS: dir_d = !arg_s[POS_W-1];
      OP_FIXED_LOC: dir_d = (arg_s >= cmd_pos[ax_d]);
      OP_IN_POS: dir_d = (arg_s >= enc_pos[ax_d]);
      default: dir_d = 1'b1;
    endcase
  end

  // Instruction capture; everything stays put while the wait is pending
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      op_q <= OP_NOP;
      ax_q <= '0;
      aux_q <= 1'b0;
      mask_q <= '0;
      tgt_q <= '0;
      dir_q <= 1'b1;
      lvl_q <= 1'b1;
      line_q <= '0;
      n_q <= '0;
    end else if (accept) begin
      op_q <= op_in;
      ax_q <= ax_d;
      aux_q <= INSTR_AUX_IN;
      mask_q <= (INSTR_AXES_IN == '0) ? '1 : INSTR_AXES_IN;
      tgt_q <= tgt_d;
      dir_q <= dir_d;
      lvl_q <= !arg_s[POS_W-1];
      line_q <= LINE_W'(arg_abs - 1'b1);
      n_q <= TIME_W'(arg_abs);
    end
  end

  // Trip conditions of the pending wait
  always_comb begin
    x_sel = aux_q ? aux_pos[ax_q] : enc_pos[ax_q];
    trip = 1'b0;
    case (op_q)
      OP_MOTION_DONE: trip = ((MOVING_IN & mask_q) == '0);
      OP_MOVE_OFFS, OP_REPEAT_OFFS, OP_FIXED_LOC: begin
        trip = dir_q ? (cmd_pos[ax_q] >= tgt_q) : (cmd_pos[ax_q] <= tgt_q);
      end
      OP_FWD_CROSS: trip = (x_sel >= tgt_q);
      OP_REV_CROSS: trip = (x_sel <= tgt_q);
      OP_IN_POS: begin
        trip = !MOVING_IN[ax_q] && (dir_q ? (enc_pos[ax_q] >= tgt_q)
                                          : (enc_pos[ax_q] <= tgt_q));
      end
      OP_IN_LEVEL: trip = (DIG_IN[line_q] == lvl_q);
      OP_CRUISE: trip = SLEW_REACHED_IN[ax_q];
      OP_REF_TIMER: trip = ((tb.now_ms - ref_q) >= n_q);
      OP_PATH_LEN: trip = ($signed(PATH_DIST_IN) >= tgt_q);
      // Ticks counted after decode; a strict greater-than guarantees at least n ms
      OP_DELAY: trip = (ms_cnt_q > n_q);
      default: trip = 1'b1;
    endcase
  end

  // Conditions are sampled only on the servo tick, so accuracy is speed times period
  assign trip_fire = (state_q == ST_WAIT) && SERVO_TICK_IN && trip;
  assign tmo_fire = (state_q == ST_WAIT) && (op_q == OP_IN_POS) && !trip_fire &&
                    (settle_q != '0) && (ms_cnt_q >= settle_q);
  assign off_trip = trip_fire && (op_q inside {OP_MOVE_OFFS, OP_REPEAT_OFFS});

  // Sequencer state: the counter is held while waiting
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (accept && (err_issue == ERR_NONE) && !imm_d) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (trip_fire || tmo_fire) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Millisecond counting for delays and the settle limit
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ms_cnt_q <= '0;
    end else if (accept) begin
      ms_cnt_q <= '0;
    end else if ((state_q == ST_WAIT) && tb.ms_tick) begin
      ms_cnt_q <= ms_cnt_q + 32'h00000001;
    end
  end

  // Reference time; stepping by n keeps periodic loops free of drift
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ref_q <= '0;
    end else if (accept && (op_in == OP_REF_TIMER) && (arg_abs == '0)) begin
      ref_q <= tb.now_ms;
    end else if (trip_fire && (op_q == OP_REF_TIMER) && !lvl_q) begin
      ref_q <= ref_q + n_q;
    end
  end

  // One-cycle answers to the sequencer
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      done_q <= 1'b0;
      error_q <= 1'b0;
      jump_q <= 1'b0;
      go_q <= 1'b0;
    end else begin
      done_q <= (accept && (err_issue == ERR_NONE) && imm_d) || trip_fire;
      error_q <= (accept && (err_issue != ERR_NONE)) || tmo_fire;
      jump_q <= tmo_fire;
      go_q <= accept && (err_issue == ERR_NONE) && (op_in == OP_REL_MOVE);
    end
  end

  // Wishbone slave: ack one cycle after the strobe, writes land at that edge
  assign wb_hit = WB_CYC_IN && WB_STB_IN && !ack_q;
  assign wb_wr = wb_hit && WB_WE_IN;
  assign err_set = (accept ? err_issue : ERR_NONE) | (tmo_fire ? ERR_TMO_M : ERR_NONE);
  assign err_clr = (wb_wr && (WB_ADR_IN == ADR_STATUS) && WB_SEL_IN[1]) ?
                   WB_DAT_IN[ST_ERR_LSB +: ERR_W] : ERR_NONE;

  // Sticky error flags; a new event beats a clear in the same cycle
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      err_q <= ERR_NONE;
    end else begin
      err_q <= (err_q & ~err_clr) | err_set;
    end
  end

  // Halt reason; a timeout beats a software clear
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      halt_q <= HALT_NONE;
      halt_ax_q <= '0;
    end else if (tmo_fire) begin
      halt_q <= HALT_SETTLE;
      halt_ax_q <= ax_q;
    end else if (wb_wr && (WB_ADR_IN == ADR_HALT) && WB_SEL_IN[0]) begin
      halt_q <= HALT_NONE;
    end
  end

  // Settle limit in ms, byte lanes honoured; zero disables the limit
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      settle_q <= SETTLE_RST;
    end else if (wb_wr && (WB_ADR_IN == ADR_SETTLE)) begin
      for (int b = 0; b < 4; b++) begin
        if (WB_SEL_IN[b]) begin
          settle_q[b*8 +: 8] <= WB_DAT_IN[b*8 +: 8];
        end
      end
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_d = 32'h00000000;
    case (WB_ADR_IN)
      ADR_STATUS: begin
        rd_d[ST_BUSY_BIT] = (state_q == ST_WAIT);
        rd_d[ST_OP_LSB +: 4] = op_q;
        rd_d[ST_ERR_LSB +: ERR_W] = err_q;
      end
      ADR_SETTLE: rd_d = settle_q;
      ADR_HALT: begin
        rd_d[7:0] = halt_q;
        rd_d[HALT_AX_LSB +: AX_W] = halt_ax_q;
      end
      ADR_TIME: rd_d = tb.now_ms;
      default: rd_d = 32'h00000000;
    endcase
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else begin
      ack_q <= wb_hit;
      if (wb_hit && !WB_WE_IN) begin
        dat_q <= rd_d;
      end
    end
  end

  assign WB_ACK_OUT = ack_q;
  assign WB_DAT_OUT = dat_q;
  assign INSTR_READY_OUT = (state_q == ST_IDLE);
  assign HOLD_OUT = (state_q == ST_WAIT);
  assign DONE_OUT = done_q;
  assign ERROR_OUT = error_q;
  assign HANDLER_JUMP_OUT = jump_q;
  assign MOVE_GO_OUT = go_q;

  // Checks on the sequencer answers, the reference step and the bus ack
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN);

  sequence tmo_s;
    tmo_fire;
  endsequence
  sequence redirect_s;
    HANDLER_JUMP_OUT && ERROR_OUT && !HOLD_OUT && !DONE_OUT;
  endsequence

  trip_done_a: assert property (trip_fire |=> DONE_OUT && !HOLD_OUT)
    else $error("trip did not advance the sequencer");
  hold_keep_a: assert property (HOLD_OUT && !trip_fire && !tmo_fire |=> HOLD_OUT)
    else $error("wait released without a trip");
  multi_refuse_a: assert property (accept && single_op && !one_axis
    |=> ERROR_OUT && !HOLD_OUT && !DONE_OUT)
    else $error("multi-axis single wait not refused");
  move_refuse_a: assert property (accept && (op_in == OP_REL_MOVE) &&
    ((MOVING_IN[N_AXES-1:0] & INSTR_AXES_IN[N_AXES-1:0]) != '0)
    |=> ERROR_OUT && !MOVE_GO_OUT)
    else $error("relative move accepted while moving");
  fwd_instant_a: assert property (accept && (op_in == OP_FWD_CROSS) && one_axis &&
    (x_new >= arg_s) |=> DONE_OUT && !HOLD_OUT)
    else $error("forward crossing did not trip at once");
  settle_tmo_a: assert property (tmo_s |=> redirect_s ##0 (halt_q == HALT_SETTLE))
    else $error("settle timeout not reported");
  servo_only_a: assert property ($fell(HOLD_OUT) |-> $past(SERVO_TICK_IN) || ERROR_OUT)
    else $error("wait released between servo samples");
  level_stall_a: assert property (HOLD_OUT && (op_q == OP_IN_LEVEL) &&
    (DIG_IN[line_q] != lvl_q) |=> HOLD_OUT)
    else $error("input wait released at wrong level");
  ref_step_a: assert property (trip_fire && (op_q == OP_REF_TIMER) && !lvl_q
    |=> ref_q == $past(ref_q) + $past(n_q))
    else $error("reference not stepped by the period");
  ack_pulse_a: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("bus ack longer than one cycle");
endmodule : tpw_top

// >>> tb/tpw_seq_model.sv
// Program sequencer model that offers one trip-point wait at a time
`timescale 1ns/100ps
module tpw_seq_model (
  input wire logic clk_in,
  input wire logic ready_in,
  input wire logic done_in,
  input wire logic error_in,
  input wire logic jump_in,
  output logic valid_out,
  output logic [3:0] op_out,
  output logic [8:0] axes_out,
  output logic aux_out,
  output logic [31:0] arg_out
);
  logic [7:0] pc_q = 8'h00;
  // Idle bus at time zero
  initial begin
    valid_out = 1'b0;
    op_out = 4'h0;
    axes_out = 9'h000;
    aux_out = 1'b0;
    arg_out = 32'h0;
  end
  // Counter moves only on completion, so a pending wait freezes it
  always @(posedge clk_in) if (done_in === 1'b1) pc_q <= pc_q + 8'h01;
  // Waits come from the stored program, never straight from a host
  task automatic issue(input logic [3:0] o, input logic [8:0] ax, input logic [31:0] a,
    input logic x, output int n, output logic d, output logic e, output logic h);
    logic r;
    @(posedge clk_in);
    valid_out <= 1'b1;
    op_out <= o;
    axes_out <= ax;
    arg_out <= a;
    aux_out <= x;
    do begin @(negedge clk_in); r = ready_in; @(posedge clk_in); end while (r !== 1'b1);
    // Operands scrambled once released, so a late read shows up
    valid_out <= 1'b0;
    axes_out <= ~ax;
    arg_out <= ~a;
    n = 0;
    do begin @(negedge clk_in); n++; end
    while (done_in !== 1'b1 && error_in !== 1'b1 && n < 4000);
    d = done_in;
    e = error_in;
    h = jump_in;
  endtask : issue
endmodule : tpw_seq_model

// >>> tb/tpw_top_tb.sv
// Self-checking bench for the trip-point wait unit
`timescale 1ns/100ps
module tpw_top_tb;
  import tpw_pkg::*;
  localparam int MSC = 10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic ack, valid, ready, done, err, jump, go, hold, aux, d, e, h;
  logic tick = 1'b0;
  logic [3:0] op;
  logic [8:0] axes;
  logic [31:0] arg;
  logic [8:0] moving = 9'h001;
  logic [7:0] slew = 8'h04;
  logic [255:0] cmd_pos = 256'h0;
  logic [255:0] enc_pos = 256'h64;
  logic [255:0] aux_pos = {192'h0, 32'hFFFFFFFB, 32'h0};
  logic [31:0] path = 32'h0000012C;
  logic [79:0] dig = 80'h1;
  int bad_count = 0;
  int total_checks = 0;
  int cyc_cnt = 0;
  int exp_pc = 0;
  int n;

  always #20 clk = ~clk;
  // Servo sample every fourth cycle, so trips land only on sample edges
  always @(posedge clk) tick <= (cyc_cnt % 4 == 3);
  // Hang guard: the whole run needs well under this many cycles
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      bad_count++;
      complete_run();
    end
  end

  tpw_top #(.MS_CYC(MSC)) tpw_top_inst (.CLK_IN(clk), .RST_IN(rst), .WB_CYC_IN(cyc),
    .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_DAT_IN(wdat), .WB_SEL_IN(sel),
    .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .INSTR_VALID_IN(valid), .INSTR_OP_IN(op),
    .INSTR_AXES_IN(axes), .INSTR_AUX_IN(aux), .INSTR_ARG_IN(arg), .INSTR_READY_OUT(ready),
    .HOLD_OUT(hold), .DONE_OUT(done), .ERROR_OUT(err), .HANDLER_JUMP_OUT(jump),
    .MOVE_GO_OUT(go), .SERVO_TICK_IN(tick), .MOVING_IN(moving), .SLEW_REACHED_IN(slew),
    .CMD_POS_IN(cmd_pos), .ENC_POS_IN(enc_pos), .AUX_POS_IN(aux_pos),
    .PATH_DIST_IN(path), .DIG_IN(dig));
  tpw_seq_model tpw_seq_model_inst (.clk_in(clk), .ready_in(ready), .done_in(done),
    .error_in(err), .jump_in(jump), .valid_out(valid), .op_out(op), .axes_out(axes),
    .aux_out(aux), .arg_out(arg));

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      bad_count++;
      $display("Error t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk
  // Twenty edges into a stall the wait must still hold the sequencer
  task automatic late;
    repeat (20) @(posedge clk);
    chk({31'h0, hold}, 32'h1);
  endtask : late
  // Classic single Wishbone cycle, held until ack is seen at an edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dt,
    input logic [3:0] s);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= dt;
    sel <= s;
    // Ack and data are sampled at the edge itself, before that edge updates them
    do @(posedge clk); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  // One instruction; xd says whether completion or refusal is due
  task automatic run(input logic [3:0] o, input logic [8:0] ax, input logic [31:0] a,
    input logic x, input logic xd);
    tpw_seq_model_inst.issue(o, ax, a, x, n, d, e, h);
    chk({31'h0, d}, {31'h0, xd});
    chk({31'h0, e}, {31'h0, ~xd});
    exp_pc += xd;
  endtask : run
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run

  // Main sequence: immediate trips and refusals first, then stalls, a timeout, then more stalls
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, ADR_SETTLE, 32'h0, 4'hF);
    chk(rd, SETTLE_RST);
    wb(1'b0, 8'h10, 32'h0, 4'hF);
    chk(rd, 32'h0);
    run(OP_FWD_CROSS, 9'h001, 32'h32, 1'b0, 1'b1);
    run(OP_REV_CROSS, 9'h002, 32'h0, 1'b1, 1'b1);
    run(OP_CRUISE, 9'h004, 32'h0, 1'b0, 1'b1);
    run(OP_PATH_LEN, 9'h100, 32'hC8, 1'b0, 1'b1);
    run(OP_MOTION_DONE, 9'h002, 32'h0, 1'b0, 1'b1);
    run(OP_REF_TIMER, 9'h000, 32'h0, 1'b0, 1'b1);
    run(OP_REL_MOVE, 9'h001, 32'h10, 1'b0, 1'b0);
    chk({31'h0, go}, 32'h0);
    run(OP_FIXED_LOC, 9'h003, 32'h0, 1'b0, 1'b0);
    run(OP_IN_LEVEL, 9'h000, 32'h51, 1'b0, 1'b0);
    run(OP_DELAY, 9'h000, 32'h2, 1'b0, 1'b1);
    chk(32'(n >= 2 * MSC && n <= 4 * MSC), 32'h1);
    fork
      run(OP_MOTION_DONE, 9'h000, 32'h0, 1'b0, 1'b1);
      begin repeat (10) @(posedge clk); late(); moving <= 9'h000; end
    join
    chk(32'(n >= 25), 32'h1);
    // Axis now at rest, so a relative move is taken and started
    run(OP_REL_MOVE, 9'h001, 32'h10, 1'b0, 1'b1);
    chk({31'h0, go}, 32'h1);
    fork
      run(OP_IN_LEVEL, 9'h000, 32'hFFFFFFFF, 1'b0, 1'b1);
      begin repeat (30) @(posedge clk); dig <= 80'h0; end
    join
    chk(32'(n >= 25), 32'h1);
    @(posedge clk);
    moving <= 9'h001;
    // Profile never ends, so the settle limit must release the wait
    wb(1'b1, ADR_SETTLE, 32'h2, 4'hF);
    run(OP_IN_POS, 9'h001, 32'h64, 1'b0, 1'b0);
    chk({31'h0, h}, 32'h1);
    chk(32'(n <= 4 * MSC), 32'h1);
    wb(1'b0, ADR_HALT, 32'h0, 4'hF);
    chk({24'h0, rd[7:0]}, {24'h0, HALT_SETTLE});
    wb(1'b0, ADR_STATUS, 32'h0, 4'hF);
    chk({28'h0, rd[ST_ERR_LSB+:ERR_W]}, 32'hF);
    wb(1'b1, ADR_STATUS, 32'h00000F00, 4'h2);
    wb(1'b0, ADR_STATUS, 32'h0, 4'hF);
    chk({28'h0, rd[ST_ERR_LSB+:ERR_W]}, 32'h0);
    // Move start captured at zero; trips land only once the command gets there
    fork
      run(OP_MOVE_OFFS, 9'h001, 32'h40, 1'b0, 1'b1);
      begin late(); cmd_pos[31:0] <= 32'h40; end
    join
    // Next trip lies a further 0x40 on from the last trip, not from move start
    fork
      run(OP_REPEAT_OFFS, 9'h001, 32'h40, 1'b0, 1'b1);
      begin @(posedge clk); cmd_pos[31:0] <= 32'h7F; late(); cmd_pos[31:0] <= 32'h80; end
    join
    fork
      run(OP_FIXED_LOC, 9'h001, 32'h20, 1'b0, 1'b1);
      begin late(); cmd_pos[31:0] <= 32'h20; end
    join
    // Settle limit off, so only profile end plus position can release it
    wb(1'b1, ADR_SETTLE, 32'h0, 4'hF);
    fork
      run(OP_IN_POS, 9'h001, 32'h64, 1'b0, 1'b1);
      begin late(); moving <= 9'h000; end
    join
    fork
      run(OP_FWD_CROSS, 9'h001, 32'hC8, 1'b0, 1'b1);
      begin late(); enc_pos[31:0] <= 32'hC8; end
    join
    // A stepped reference makes the following wait a full period long
    run(OP_REF_TIMER, 9'h000, 32'h0, 1'b0, 1'b1);
    run(OP_REF_TIMER, 9'h000, 32'hFFFFFFFD, 1'b0, 1'b1);
    run(OP_REF_TIMER, 9'h000, 32'h3, 1'b0, 1'b1);
    chk(32'(n >= 2 * MSC), 32'h1);
    @(negedge clk);
    chk({24'h0, tpw_seq_model_inst.pc_q}, 32'(exp_pc));
    complete_run();
  end
endmodule : tpw_top_tb
